// ### hw/frit_pkg.sv
// Package with register indices, timing constants and carrier types of the timer block.
package frit_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] FREE_LOW_IDX = 8'h20;
  localparam logic [7:0] FREE_HIGH_IDX = 8'h21;
  localparam logic [7:0] INTERVAL_LOW_IDX = 8'h26;
  localparam logic [7:0] INTERVAL_HIGH_IDX = 8'h27;
  localparam logic [7:0] RELOAD_LOW_IDX = 8'h28;
  localparam logic [7:0] RELOAD_HIGH_IDX = 8'h29;
  localparam int unsigned REG_INDEX_SHIFT = 2;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] FREE_RESET = 16'h0000;
  localparam logic [11:0] INTERVAL_RESET = 12'h000;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

  localparam int unsigned FREE_WIDTH = 16;
  localparam int unsigned INTERVAL_WIDTH = 12;

  // Core clock and timer time base.
  localparam int unsigned CORE_CLK_KHZ = 100000;
  localparam int unsigned TIMER_CLK_KHZ = 4000;
  localparam int unsigned TIMER_DIV = CORE_CLK_KHZ / TIMER_CLK_KHZ;

  // Periodic tick interval in microseconds and its length in timer counts.
  localparam int unsigned TICK_PERIOD_US = 1024;
  localparam int unsigned TICK_COUNTS = TICK_PERIOD_US * TIMER_CLK_KHZ / 1000;
  localparam int unsigned TICK_BITS = $clog2(TICK_COUNTS);

  // Counter wrap period in milliseconds and its length in timer counts.
  localparam real WRAP_PERIOD_MS = 16.384;
  localparam int unsigned WRAP_COUNTS = int'(WRAP_PERIOD_MS * TIMER_CLK_KHZ);

  typedef struct packed {
    logic tick;
    logic wrap;
    logic interval;
  } frit_irq_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] index;
  } frit_dphase_t;

endpackage

// ### hw/frit_prescaler.sv
// Divider that turns the core clock into the one-cycle timer count enable.
`timescale 1ns/1ns
module frit_prescaler #(
  parameter int unsigned DIV = frit_pkg::TIMER_DIV
) (
  input wire logic core_clk,
  input wire logic resetn,
  output logic timer_en
);
  import frit_pkg::*;

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ZERO = '0;
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] count;
  wire at_last = (count == LAST);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= ZERO;
      timer_en <= 1'b0;
    end
    else
    begin
      count <= at_last ? ZERO : count + ONE;
      timer_en <= at_last;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_enable_spacing: assert property (timer_en |-> count == ZERO && $past(count) == LAST)
    else $error("timer enable not at divider end");

endmodule // frit_prescaler

// ### hw/frit_timer_top.sv
// Free-running 16-bit counter and 12-bit interval timer behind an AHB-Lite register slave.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module frit_timer_top #(
  parameter int unsigned DIV = frit_pkg::TIMER_DIV
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output frit_pkg::frit_irq_t irq
);
  import frit_pkg::*;

  logic timer_en;
  logic [15:0] free_count;
  logic [7:0] free_low_buf;
  logic [7:0] free_hold;
  logic [11:0] interval_count;
  logic [3:0] interval_hold;
  logic [7:0] reload_low;
  logic [3:0] reload_high;
  frit_dphase_t dphase;

  // The timer time base is an enable from the core clock, so no register crosses domains.
  frit_prescaler #(
    .DIV(DIV)
  ) u_prescaler (
    .core_clk(core_clk),
    .resetn(resetn),
    .timer_en(timer_en)
  );

  // Address phase decode.
  wire [7:0] ap_index = haddr[7 + REG_INDEX_SHIFT:REG_INDEX_SHIFT];
  wire ap_aligned = (haddr[31:8 + REG_INDEX_SHIFT] == '0) && (haddr[REG_INDEX_SHIFT-1:0] == '0);
  wire ap_accept = hsel && hready && htrans[1];
  wire ap_read = ap_accept && !hwrite;
  wire rd_free_low = ap_read && ap_aligned && (ap_index == FREE_LOW_IDX);
  wire rd_interval_low = ap_read && ap_aligned && (ap_index == INTERVAL_LOW_IDX);

  // Data phase write strobes.
  wire dp_write = dphase.valid && dphase.write;
  wire wr_free_low = dp_write && (dphase.index == FREE_LOW_IDX);
  wire wr_free_high = dp_write && (dphase.index == FREE_HIGH_IDX);
  wire wr_reload_low = dp_write && (dphase.index == RELOAD_LOW_IDX);
  wire wr_reload_high = dp_write && (dphase.index == RELOAD_HIGH_IDX);

  // Read data selection; unmapped and reserved bits read as zero.
  wire [7:0] rd_byte =
    !ap_aligned ? REG_RESET :
    (ap_index == FREE_LOW_IDX) ? free_count[7:0] :
    (ap_index == FREE_HIGH_IDX) ? free_hold :
    (ap_index == INTERVAL_LOW_IDX) ? interval_count[7:0] :
    (ap_index == INTERVAL_HIGH_IDX) ? {4'h0, interval_hold} :
    (ap_index == RELOAD_LOW_IDX) ? reload_low :
    (ap_index == RELOAD_HIGH_IDX) ? {4'h0, reload_high} :
    REG_RESET;

  // Counter and interval events.
  wire [15:0] next_free = free_count + 16'h0001;
  wire tick_hit = timer_en && !wr_free_high && (free_count[TICK_BITS-1:0] == '1);
  wire wrap_hit = timer_en && !wr_free_high && (free_count == '1);
  wire interval_zero = (interval_count == INTERVAL_RESET);
  wire [11:0] reload_value = {reload_high, reload_low};

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dphase <= '0;
      hrdata <= HRDATA_RESET;
    end
    else
    begin
      if (hready)
      begin
        dphase.valid <= ap_accept && ap_aligned;
        dphase.write <= hwrite;
        dphase.index <= ap_index;
      end
      if (ap_read)
      begin
        hrdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      free_count <= FREE_RESET;
      free_low_buf <= REG_RESET;
      free_hold <= REG_RESET;
    end
    else
    begin
      if (wr_free_high)
      begin
        free_count <= {hwdata[7:0], free_low_buf};
      end
      else if (timer_en)
      begin
        free_count <= next_free;
      end
      if (wr_free_low)
      begin
        free_low_buf <= hwdata[7:0];
      end
      if (rd_free_low)
      begin
        free_hold <= free_count[15:8];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      interval_count <= INTERVAL_RESET;
      interval_hold <= NIBBLE_RESET;
      reload_low <= REG_RESET;
      reload_high <= NIBBLE_RESET;
    end
    else
    begin
      if (timer_en)
      begin
        interval_count <= interval_zero ? reload_value : interval_count - 12'h001;
      end
      if (rd_interval_low)
      begin
        interval_hold <= interval_count[11:8];
      end
      if (wr_reload_low)
      begin
        reload_low <= hwdata[7:0];
      end
      if (wr_reload_high)
      begin
        reload_high <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq <= '0;
    end
    else
    begin
      irq.tick <= tick_hit;
      irq.wrap <= wrap_hit;
      irq.interval <= timer_en && interval_zero;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_free_count_step: assert property (timer_en && !wr_free_high |=> free_count == $past(next_free))
    else $error("free counter did not step on timer enable");

  a_free_count_still: assert property (!timer_en && !wr_free_high |=> $stable(free_count))
    else $error("free counter changed without enable or load");

  a_high_latch: assert property (rd_free_low |=> free_hold == $past(free_count[15:8]))
    else $error("upper byte not held on low byte read");

  // A single-transfer master leaves one idle data phase between the low and the high read.
  a_atomic_sample: assert property (
    rd_free_low ##1 !ap_read ##1 (ap_read && ap_aligned && ap_index == FREE_HIGH_IDX)
    |=> {hrdata[7:0], $past(hrdata[7:0])} == $past(free_count, 3))
    else $error("16-bit sample not taken at one instant");

  a_high_load: assert property (wr_free_high |=> free_count == {$past(hwdata[7:0]), $past(free_low_buf)})
    else $error("upper byte write did not load sixteen bits");

  a_low_buffered: assert property (wr_free_low && !timer_en |=> $stable(free_count))
    else $error("low byte write changed the counter");

  a_tick_place: assert property (irq.tick |-> free_count[TICK_BITS-1:0] == '0 && $past(timer_en))
    else $error("tick request off its period boundary");

  a_wrap_place: assert property (irq.wrap |-> free_count == FREE_RESET && irq.tick)
    else $error("wrap request without overflow");

  a_interval_reload: assert property (timer_en && interval_zero
    |=> interval_count == $past(reload_value) && irq.interval)
    else $error("interval timer did not reload with request");

  a_interval_nibble: assert property (rd_interval_low |=> interval_hold == $past(interval_count[11:8]))
    else $error("interval nibble not latched");

  a_reserved_zero: assert property (hrdata[31:8] == '0 && !hresp)
    else $error("reserved read bits or response not zero");

  a_nibble_read: assert property (ap_read && ap_aligned && ap_index == INTERVAL_HIGH_IDX
    |=> hrdata[7:0] == {4'h0, $past(interval_hold)})
    else $error("interval high read not the held nibble");

endmodule // frit_timer_top

// ### verif/testbench.sv
// Self-checking bench for the timer block: AHB-Lite register access, latching, loading and timer events.
`timescale 1ns/1ns
module testbench;
  import frit_pkg::*;
  localparam int unsigned DIV = 2;
  logic core_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, rh, v0, v1;
  logic [1:0] htrans;
  logic [2:0] hsize;
  frit_irq_t irq;
  int error_cnt, samples_checked, n;
  logic [31:0] zero_addr [6] = '{32'h84, 32'h98, 32'h9c, 32'ha0, 32'ha4, 32'h88};
  assign hready = hreadyout;
  frit_timer_top #(.DIV(DIV)) dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .irq(irq)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // Waits for the rising edge at which hready is sampled high.
  task wait_ready;
    int i;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  // One single word transfer: address phase, then data phase; read data taken at the closing edge.
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_ready;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    q = hrdata;
  endtask
  // Counts clock edges until the chosen event bit pulses; the pulse is seen at the edge after its launch.
  task wait_irq(input int b, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge core_clk);
      cnt++;
    end while (irq[b] !== 1'b1 && cnt < 20000);
    if (irq[b] !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task read_free(output logic [31:0] val);
    logic [31:0] lo, hi;
    bus(1'b0, 32'h80, 32'h0, lo);
    bus(1'b0, 32'h84, 32'h0, hi);
    val = {16'h0, hi[7:0], lo[7:0]};
  endtask
  initial
  begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    check({29'h0, irq}, 32'h0);
    foreach (zero_addr[i])
    begin
      bus(1'b0, zero_addr[i], 32'h0, rd);
      check(rd, 32'h0);
    end
    check({31'h0, hresp}, 32'h0);
    bus(1'b1, 32'ha0, 32'hffff_ff05, rd);
    bus(1'b1, 32'ha4, 32'hffff_fff1, rd);
    bus(1'b0, 32'ha0, 32'h0, rd);
    check(rd, 32'h05);
    bus(1'b0, 32'ha4, 32'h0, rd);
    check(rd, 32'h01);
    wait_irq(0, n);
    wait_irq(0, n);
    wait_irq(0, n);
    check(n, (32'h105 + 1) * DIV);
    bus(1'b0, 32'h98, 32'h0, rd);
    repeat (40) @(posedge core_clk);
    bus(1'b0, 32'h9c, 32'h0, rh);
    check_range({20'h0, rh[3:0], rd[7:0]}, 32'h100, 32'h105);
    check(rh & 32'hffff_fff0, 32'h0);
    bus(1'b1, 32'h80, 32'hfe, rd);
    bus(1'b1, 32'h84, 32'h12, rd);
    bus(1'b0, 32'h80, 32'h0, rd);
    repeat (600) @(posedge core_clk);
    bus(1'b0, 32'h84, 32'h0, rh);
    v0 = {16'h0, rh[7:0], rd[7:0]};
    check_range(v0, 32'h12fe, 32'h1308);
    read_free(v1);
    check_range(v1, v0 + 32'h120, v0 + 32'h140);
    bus(1'b1, 32'h80, 32'h00, rd);
    read_free(v0);
    check_range(v0, v1 + 32'h1, v1 + 32'h10);
    bus(1'b1, 32'h80, 32'hf0, rd);
    bus(1'b1, 32'h84, 32'hff, rd);
    wait_irq(1, n);
    check_range(n, 28, 36);
    check({31'h0, irq.tick}, 32'h1);
    wait_irq(2, n);
    check(n, TICK_COUNTS * DIV);
    tally_and_finish;
  end
endmodule // testbench
